// file: nco_phase_accumulator_regs.sv
// Phase accumulator, double-buffered step and APB registers.
// Assumes an APB master on pclk and synchronous source levels.
//
// Summary of operation
// - Accumulator 20 bits, upper byte top reads zero
// - Accumulator runs freely, reads not coherent
// - Step 20 bits, upper byte top reads zero
// - Working step loads on falling source edge
// - Reset sets step to one
// - Reset clears accumulator, bytes read/write
// - Four-bit code selects source clock
// - Pulse width used only in pulse mode
`timescale 1ns/1ps
`include "nco_params.svh"

module nco_phase_accumulator_regs
  import nco_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [`NUM_SRC_MSB:`SRC_LO]  src_in,
  output logic                              osc_out,
  output logic                              overflow_pulse,
  output logic                              irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic phase_type put_byte(input phase_type v, input logic [1:0] lane,
                                         input byte_type b);
    phase_type r;
    r = v;
    unique case (lane)
      `LANE_LOW:  r[7:0] = b;
      `LANE_HIGH: r[15:8] = b;
      default:    r[`PHASE_MSB:16] = b[3:0];
    endcase
    return r;
  endfunction

  function automatic byte_type get_byte(input phase_type v, input logic [1:0] lane);
    byte_type r;
    r = 8'h00;
    unique case (lane)
      `LANE_LOW:  r = v[7:0];
      `LANE_HIGH: r = v[15:8];
      default:    r = {`UPPER_PAD, v[`PHASE_MSB:16]};
    endcase
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `OFS_CONTROL || a == `OFS_CLOCK_CFG || a == `OFS_ACC_LOW ||
           a == `OFS_ACC_HIGH || a == `OFS_ACC_UPPER || a == `OFS_STEP_LOW ||
           a == `OFS_STEP_HIGH || a == `OFS_STEP_UPPER || a == `OFS_IRQ_STATUS ||
           a == `OFS_IRQ_CLEAR || a == `OFS_IRQ_ENABLE;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic            en_reg, en_next, pol_reg, pol_next, pfm_reg, pfm_next;
  logic [2:0]      pws_reg, pws_next;
  logic [3:0]      cks_reg, cks_next;
  phase_type       acc_reg, acc_next, step_reg, step_next, work_reg, work_next;
  logic            pending_reg, pending_next;
  logic            out_reg, out_next, osc_reg, osc_next, ovf_reg;
  pulse_state_type pulse_state_reg, pulse_state_next;
  logic [`PCNT_W-1:0] pcnt_reg, pcnt_next, pwidth;
  logic            status_reg, status_next, irq_en_reg, irq_en_next;
  logic [31:0]     prdata_reg, prdata_next;
  logic            rise_tick, fall_tick, ovf_event;
  logic            wr, setup;
  logic [1:0]      lane;
  logic [`PHASE_W:0] sum;

  nco_source_select u_src (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_in    (src_in),
    .cks       (cks_reg),
    .rise_tick (rise_tick),
    .fall_tick (fall_tick)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata  = prdata_reg;
  assign lane    = (paddr == `OFS_ACC_LOW || paddr == `OFS_STEP_LOW) ? `LANE_LOW :
                   (paddr == `OFS_ACC_HIGH || paddr == `OFS_STEP_HIGH) ? `LANE_HIGH :
                   `LANE_UPPER;

  // Read data captured in setup, shown in access
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        `OFS_CONTROL: begin
          prdata_next[`CTL_EN_BIT]  = en_reg;
          prdata_next[`CTL_OUT_BIT] = out_reg;
          prdata_next[`CTL_POL_BIT] = pol_reg;
          prdata_next[`CTL_PFM_BIT] = pfm_reg;
        end
        `OFS_CLOCK_CFG: begin
          prdata_next[`CLK_PWS_HI:`CLK_PWS_LO] = pws_reg;
          prdata_next[`CLK_CKS_HI:`CLK_CKS_LO] = cks_reg;
        end
        `OFS_ACC_LOW, `OFS_ACC_HIGH, `OFS_ACC_UPPER:
          prdata_next[7:0] = get_byte(acc_reg, lane);
        `OFS_STEP_LOW, `OFS_STEP_HIGH, `OFS_STEP_UPPER:
          prdata_next[7:0] = get_byte(step_reg, lane);
        `OFS_IRQ_STATUS: prdata_next[`IRQ_OVF_BIT] = status_reg;
        `OFS_IRQ_ENABLE: prdata_next[`IRQ_OVF_BIT] = irq_en_reg;
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration and step registers
  // ----------------------------------------------------------------
  always_comb begin
    en_next      = en_reg;
    pol_next     = pol_reg;
    pfm_next     = pfm_reg;
    pws_next     = pws_reg;
    cks_next     = cks_reg;
    step_next    = step_reg;
    irq_en_next  = irq_en_reg;
    work_next    = work_reg;
    pending_next = pending_reg;
    if (pending_reg && fall_tick) begin
      work_next    = step_reg;
      pending_next = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        `OFS_CONTROL: begin
          en_next  = pwdata[`CTL_EN_BIT];
          pol_next = pwdata[`CTL_POL_BIT];
          pfm_next = pwdata[`CTL_PFM_BIT];
        end
        `OFS_CLOCK_CFG: begin
          pws_next = pwdata[`CLK_PWS_HI:`CLK_PWS_LO];
          cks_next = pwdata[`CLK_CKS_HI:`CLK_CKS_LO];
        end
        `OFS_STEP_LOW: begin
          step_next    = put_byte(step_reg, lane, pwdata[7:0]);
          pending_next = 1'b1;
        end
        `OFS_STEP_HIGH, `OFS_STEP_UPPER:
          step_next = put_byte(step_reg, lane, pwdata[7:0]);
        `OFS_IRQ_ENABLE: irq_en_next = pwdata[`IRQ_OVF_BIT];
        default: en_next = en_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, output and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    sum              = {1'b0, acc_reg} + {1'b0, work_reg};
    acc_next         = acc_reg;
    ovf_event        = 1'b0;
    out_next         = out_reg;
    pulse_state_next = pulse_state_reg;
    pcnt_next        = pcnt_reg;
    pwidth           = `PCNT_W'(1) << pws_reg;
    if (en_reg && rise_tick) begin
      acc_next  = sum[`PHASE_MSB:0];
      ovf_event = sum[`PHASE_W];
    end
    if (wr && (paddr == `OFS_ACC_LOW || paddr == `OFS_ACC_HIGH || paddr == `OFS_ACC_UPPER)) begin
      acc_next = put_byte(acc_reg, lane, pwdata[7:0]);
    end
    if (!pfm_reg) begin
      pulse_state_next = PULSE_IDLE;
      if (ovf_event) begin
        out_next = ~out_reg;
      end
    end else begin
      unique case (pulse_state_reg)
        PULSE_IDLE: begin
          if (ovf_event) begin
            out_next         = 1'b1;
            pcnt_next        = '0;
            pulse_state_next = PULSE_ACTIVE;
          end else begin
            out_next = 1'b0;
          end
        end
        PULSE_ACTIVE: begin
          if (rise_tick) begin
            pcnt_next = pcnt_reg + `PCNT_W'(1);
            if (pcnt_reg + `PCNT_W'(1) >= pwidth) begin
              out_next         = 1'b0;
              pulse_state_next = PULSE_IDLE;
            end
          end
        end
      endcase
    end
    osc_next    = out_next ^ pol_next;
    // Set wins over a clear in the same cycle
    status_next = status_reg;
    if (wr && paddr == `OFS_IRQ_CLEAR && pwdata[`IRQ_OVF_BIT]) begin
      status_next = 1'b0;
    end
    if (ovf_event) begin
      status_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg          <= 1'b0;
      pol_reg         <= 1'b0;
      pfm_reg         <= 1'b0;
      pws_reg         <= 3'h0;
      cks_reg         <= `CKS_SYSCLK;
      step_reg        <= `STEP_RESET;
      work_reg        <= `STEP_RESET;
      pending_reg     <= 1'b0;
      acc_reg         <= `ACC_RESET;
      out_reg         <= 1'b0;
      osc_reg         <= 1'b0;
      ovf_reg         <= 1'b0;
      pulse_state_reg <= PULSE_IDLE;
      pcnt_reg        <= '0;
      status_reg      <= 1'b0;
      irq_en_reg      <= 1'b0;
      prdata_reg      <= 32'h0000_0000;
    end else begin
      en_reg          <= en_next;
      pol_reg         <= pol_next;
      pfm_reg         <= pfm_next;
      pws_reg         <= pws_next;
      cks_reg         <= cks_next;
      step_reg        <= step_next;
      work_reg        <= work_next;
      pending_reg     <= pending_next;
      acc_reg         <= acc_next;
      out_reg         <= out_next;
      osc_reg         <= osc_next;
      ovf_reg         <= ovf_event;
      pulse_state_reg <= pulse_state_next;
      pcnt_reg        <= pcnt_next;
      status_reg      <= status_next;
      irq_en_reg      <= irq_en_next;
      prdata_reg      <= prdata_next;
    end
  end

  assign osc_out        = osc_reg;
  assign overflow_pulse = ovf_reg;
  assign irq            = status_reg & irq_en_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ACC_UPPER_PAD: assert property (
    (setup && paddr == `OFS_ACC_UPPER) |=> prdata[7:4] == `UPPER_PAD)
    else $error("accumulator upper byte high nibble not zero");

  AST_ACC_READ_LIVE: assert property (
    (setup && paddr == `OFS_ACC_LOW) |=> prdata[7:0] == $past(acc_reg[7:0]))
    else $error("accumulator read does not show live value");

  AST_STEP_UPPER_PAD: assert property (
    (setup && paddr == `OFS_STEP_UPPER) |=> prdata[7:4] == `UPPER_PAD)
    else $error("step upper byte high nibble not zero");

  AST_STEP_LOAD: assert property (
    (pending_reg && fall_tick) |=> work_reg == $past(step_reg) &&
      (!pending_reg || $past(wr && paddr == `OFS_STEP_LOW)))
    else $error("working step not loaded on falling edge");

  AST_STEP_WAIT: assert property (
    !(pending_reg && fall_tick) |=> work_reg == $past(work_reg))
    else $error("working step changed without a load");

  AST_RESET_VALUES: assert property (disable iff (1'b0)
    !presetn |=> step_reg == `STEP_RESET && acc_reg == `ACC_RESET)
    else $error("reset values wrong");

  AST_PWS_IGNORED: assert property (
    !$past(pfm_reg) |-> pulse_state_reg == PULSE_IDLE)
    else $error("pulse state active in fixed duty mode");

  AST_ACC_ADVANCE: assert property (
    (en_reg && rise_tick && !wr) |=> acc_reg == $past(acc_reg) + $past(work_reg))
    else $error("accumulator did not add the step");

  AST_OVF_FLAG: assert property (
    ovf_event |=> status_reg ##0 overflow_pulse)
    else $error("overflow did not set flag and pulse");

  AST_HOLD_DISABLED: assert property (
    (!en_reg && !wr) |=> $stable(acc_reg) && !overflow_pulse)
    else $error("accumulator moved while disabled");

endmodule

// file: nco_params.svh
// Constants of the phase accumulator block: offsets, fields, resets.
// Assumes inclusion by the package and the modules by bare name.
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PHASE_W      20
`define PHASE_MSB    19
`define NUM_SRC_MSB  10
`define SRC_LO       1
`define PCNT_W       8

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_CONTROL    8'h00
`define OFS_CLOCK_CFG  8'h04
`define OFS_ACC_LOW    8'h08
`define OFS_ACC_HIGH   8'h0c
`define OFS_ACC_UPPER  8'h10
`define OFS_STEP_LOW   8'h14
`define OFS_STEP_HIGH  8'h18
`define OFS_STEP_UPPER 8'h1c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_CLEAR  8'h24
`define OFS_IRQ_ENABLE 8'h28

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTL_EN_BIT    7
`define CTL_OUT_BIT   5
`define CTL_POL_BIT   4
`define CTL_PFM_BIT   0
`define CLK_PWS_HI    7
`define CLK_PWS_LO    5
`define CLK_CKS_HI    3
`define CLK_CKS_LO    0
`define IRQ_OVF_BIT   0
`define LANE_LOW      2'h0
`define LANE_HIGH     2'h1
`define LANE_UPPER    2'h2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define STEP_RESET    20'h00001
`define ACC_RESET     20'h00000
`define CKS_SYSCLK    4'h0
`define CKS_LAST      4'ha
`define UPPER_PAD     4'h0

`endif

// file: nco_pkg.sv
// Types shared by the phase accumulator modules.
// Assumes nco_params.svh is on the include path.
`include "nco_params.svh"

package nco_pkg;
  typedef logic [`PHASE_MSB:0] phase_type;
  typedef logic [7:0]          byte_type;
  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_state_type;
endpackage

// file: nco_source_select.sv
// Source clock selector with edge ticks for the oscillator.
// Assumes source levels are synchronous to pclk.
`timescale 1ns/1ps
`include "nco_params.svh"

module nco_source_select
  import nco_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [`NUM_SRC_MSB:`SRC_LO]  src_in,
  input  wire logic [3:0]                   cks,
  output logic                              rise_tick,
  output logic                              fall_tick
);

  logic level_reg;
  logic level_next;

  // ----------------------------------------------------------------
  // Selection and edges
  // ----------------------------------------------------------------
  always_comb begin
    level_next = 1'b0;
    if (cks != `CKS_SYSCLK && cks <= `CKS_LAST) begin
      level_next = src_in[cks];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  // System clock code ticks every cycle
  assign rise_tick = (cks == `CKS_SYSCLK) | (level_next & ~level_reg);
  assign fall_tick = (cks == `CKS_SYSCLK) | (~level_next & level_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SYSCLK_TICKS: assert property (@(posedge pclk) disable iff (!presetn)
    cks == `CKS_SYSCLK |-> rise_tick && fall_tick)
    else $error("system clock code does not tick");

  AST_RESERVED_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
    (cks > `CKS_LAST && $past(cks) > `CKS_LAST) |-> !rise_tick && !fall_tick)
    else $error("reserved source code produced a tick");

endmodule

// file: nco_phase_accumulator_regs_tb.sv
// Self-checking bench for the phase accumulator register block.
// Assumes nco_params.svh and nco_pkg are compiled first; APB master only.
`timescale 1ns/1ps
`include "nco_params.svh"

module nco_phase_accumulator_regs_tb
  import nco_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [`NUM_SRC_MSB:`SRC_LO] src_in;
  logic        osc_out;
  logic        overflow_pulse;
  logic        irq;
  int          fail_count = 0;
  int          n_checks = 0;
  int          ovf_seen = 0;
  int          ovf_exp = 0;
  phase_type   acc_exp;

  nco_phase_accumulator_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_in(src_in), .osc_out(osc_out), .overflow_pulse(overflow_pulse), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (overflow_pulse === 1'b1) ovf_seen <= ovf_seen + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 8'h00, rd, e);
    check(name, exp, rd);
  endtask

  task automatic read_acc(output phase_type v);
    logic [31:0] l, h, u;
    logic e;
    apb(1'b0, `OFS_ACC_LOW, 8'h00, l, e);
    apb(1'b0, `OFS_ACC_HIGH, 8'h00, h, e);
    apb(1'b0, `OFS_ACC_UPPER, 8'h00, u, e);
    v = {u[3:0], h[7:0], l[7:0]};
  endtask

  // One rise then one fall on the masked source lines
  task automatic pulse(input logic [`NUM_SRC_MSB:`SRC_LO] m);
    @(posedge pclk);
    src_in <= m;
    repeat (4) @(posedge pclk);
    src_in <= 10'h000;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [10] = '{`OFS_CONTROL, `OFS_CLOCK_CFG, `OFS_ACC_LOW, `OFS_ACC_HIGH, `OFS_ACC_UPPER,
                             `OFS_STEP_LOW, `OFS_STEP_HIGH, `OFS_STEP_UPPER, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    check("osc_out_rst", 32'h0, {31'h0, osc_out});
    check("irq_rst", 32'h0, {31'h0, irq});
    for (int i = 0; i < 10; i++) begin
      rd_chk("reset_value", ofs[i], {24'h000000, rv[i]});
    end
  endtask

  task automatic t_access();
    logic [31:0] rd;
    logic e;
    wr(`OFS_ACC_LOW, 8'ha5);
    wr(`OFS_ACC_HIGH, 8'h5a);
    wr(`OFS_ACC_UPPER, 8'hff);
    rd_chk("acc_low", `OFS_ACC_LOW, 32'h000000a5);
    rd_chk("acc_high", `OFS_ACC_HIGH, 32'h0000005a);
    rd_chk("acc_upper", `OFS_ACC_UPPER, 32'h0000000f);
    wr(`OFS_STEP_HIGH, 8'hc3);
    wr(`OFS_STEP_UPPER, 8'hff);
    rd_chk("step_high", `OFS_STEP_HIGH, 32'h000000c3);
    rd_chk("step_upper", `OFS_STEP_UPPER, 32'h0000000f);
    wr(8'h2c, 8'hff);
    apb(1'b0, 8'h2c, 8'h00, rd, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_data", 32'h0, rd);
  endtask

  task automatic t_step_load();
    phase_type v;
    wr(`OFS_CLOCK_CFG, 8'h01);
    wr(`OFS_ACC_LOW, 8'h00);
    wr(`OFS_ACC_HIGH, 8'h00);
    wr(`OFS_ACC_UPPER, 8'h00);
    wr(`OFS_STEP_UPPER, 8'h08);
    wr(`OFS_STEP_HIGH, 8'h00);
    wr(`OFS_STEP_LOW, 8'h00);
    wr(`OFS_CONTROL, 8'h80);
    pulse(10'h001);
    read_acc(v);
    check("acc_old_step", 32'h00001, {12'h000, v});
    pulse(10'h001);
    read_acc(v);
    check("acc_new_step", 32'h80001, {12'h000, v});
    pulse(10'h001);
    read_acc(v);
    check("acc_wrap", 32'h00001, {12'h000, v});
    ovf_exp = 1;
    check("ovf_count", ovf_exp, ovf_seen);
    check("osc_toggle", 32'h1, {31'h0, osc_out});
  endtask

  task automatic t_codes();
    phase_type v;
    logic c;
    acc_exp = 20'h00001;
    for (int k = 1; k <= 10; k++) begin
      wr(`OFS_CLOCK_CFG, {4'he, k[3:0]});
      pulse(10'h001 << (k - 1));
      {c, acc_exp} = {1'b0, acc_exp} + 21'h080000;
      ovf_exp += c;
      read_acc(v);
      check("acc_per_code", {12'h000, acc_exp}, {12'h000, v});
    end
    check("ovf_count", ovf_exp, ovf_seen);
    check("osc_fixed_duty", ovf_exp % 2, {31'h0, osc_out});
    for (int k = 11; k <= 15; k++) begin
      wr(`OFS_CLOCK_CFG, {4'h0, k[3:0]});
      pulse(10'h3ff);
      read_acc(v);
      check("acc_reserved_code", {12'h000, acc_exp}, {12'h000, v});
    end
  endtask

  task automatic t_disabled();
    phase_type v1, v2;
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_ACC_LOW, 8'h00);
    wr(`OFS_ACC_HIGH, 8'h00);
    wr(`OFS_ACC_UPPER, 8'h00);
    wr(`OFS_STEP_UPPER, 8'h00);
    wr(`OFS_STEP_HIGH, 8'h00);
    wr(`OFS_STEP_LOW, 8'h01);
    wr(`OFS_CLOCK_CFG, 8'h00);
    wr(`OFS_CONTROL, 8'h80);
    repeat (8) @(posedge pclk);
    wr(`OFS_CONTROL, 8'h00);
    read_acc(v1);
    check("acc_sysclk_moved", 32'h1, {31'h0, v1 !== 20'h00000});
    repeat (20) @(posedge pclk);
    read_acc(v2);
    check("acc_held", {12'h000, v1}, {12'h000, v2});
    check("ovf_none", ovf_exp, ovf_seen);
  endtask

  // Pulse mode, width code 1, inverted output
  task automatic t_pulse();
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_STEP_UPPER, 8'h04);
    wr(`OFS_STEP_HIGH, 8'h00);
    wr(`OFS_STEP_LOW, 8'h00);
    wr(`OFS_CLOCK_CFG, 8'h21);
    wr(`OFS_ACC_LOW, 8'h00);
    wr(`OFS_ACC_HIGH, 8'h00);
    wr(`OFS_ACC_UPPER, 8'h0c);
    wr(`OFS_CONTROL, 8'h91);
    pulse(10'h001);
    ovf_exp++;
    rd_chk("pulse_start", `OFS_CONTROL, 32'h000000b1);
    check("osc_pulse_pol", 32'h0, {31'h0, osc_out});
    pulse(10'h001);
    rd_chk("pulse_held", `OFS_CONTROL, 32'h000000b1);
    pulse(10'h001);
    rd_chk("pulse_end", `OFS_CONTROL, 32'h00000091);
    check("osc_pulse_end", 32'h1, {31'h0, osc_out});
    check("ovf_count", ovf_exp, ovf_seen);
  endtask

  task automatic t_irq();
    rd_chk("irq_status", `OFS_IRQ_STATUS, 32'h1);
    check("irq_masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge pclk);
    check("irq_on", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge pclk);
    check("irq_off", 32'h0, {31'h0, irq});
    rd_chk("irq_status_clr", `OFS_IRQ_STATUS, 32'h0);
    rd_chk("irq_enable", `OFS_IRQ_ENABLE, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    src_in = 10'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_access();
    t_step_load();
    t_codes();
    t_disabled();
    t_pulse();
    t_irq();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
endmodule
